/* verilog/fal_pkg.sv */
// Constants for the severe-fault and alert trigger-mask block.
// Assumes a 16-bit register command port supplied by the module's protocol engine.
package fal_pkg;

  // Register numbers on the command port
  localparam logic [7:0]  SEVERE_MASK_ADDR = 8'h29;
  localparam logic [7:0]  ALERT_MASK_ADDR  = 8'h2a;

  // Reset values
  localparam logic [15:0] SEVERE_MASK_RESET = 16'h000f;
  localparam logic [15:0] ALERT_MASK_RESET  = 16'h0404;
  localparam logic [15:0] ERROR_DATA        = 16'h0000;

  // Status-layout field positions
  localparam int WARN_VENDOR_BIT   = 11;
  localparam int WARN_FREQ_BIT     = 10;
  localparam int WARN_THERMAL_BIT  = 9;
  localparam int WARN_POWER_BIT    = 8;
  localparam int RESTART_BIT       = 5;
  localparam int SEV_VENDOR_BIT    = 3;
  localparam int SEV_FREQ_BIT      = 2;
  localparam int SEV_THERMAL_BIT   = 1;
  localparam int SEV_POWER_BIT     = 0;

  // Bits that only count while the laser is locked
  localparam logic [15:0] LOCK_QUALIFIED_BITS = 16'h0707;

  // Response status field
  typedef enum logic [1:0] {
    RSP_OK       = 2'h0,
    RSP_EXEC_ERR = 2'h1
  } fal_status_t;

  // Error condition field
  typedef enum logic [3:0] {
    ERR_OK        = 4'h0,
    ERR_READ_ONLY = 4'h1,
    ERR_BUSY      = 4'h3,
    ERR_IGNORED   = 4'h4,
    ERR_EXEC_FAIL = 4'h5,
    ERR_VENDOR    = 4'hf
  } fal_error_t;

endpackage : fal_pkg

/* verilog/fal_mask_if.sv */
// Carrier between the trigger top and one mask register.
// Assumes both ends share the top module's clock.
`timescale 1ns/10ps
`default_nettype none
interface fal_mask_if;
  logic        writeEn;
  logic [15:0] writeData;
  logic        restoreEn;
  logic [15:0] restoreData;
  logic [15:0] mask;

  modport owner (input writeEn, writeData, restoreEn, restoreData, output mask);
  modport user  (output writeEn, writeData, restoreEn, restoreData, input mask);
endinterface : fal_mask_if
`default_nettype wire

/* verilog/fal_mask_reg.sv */
// One 16-bit trigger mask with a reset value and a non-volatile restore path.
// Assumes write and restore are single-cycle strobes on the common clock.
`timescale 1ns/10ps
`default_nettype none
module fal_mask_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Mask carrier
  fal_mask_if.owner  port
);

  logic [15:0] mask_q;

  // Restore of a saved configuration wins over a same-cycle host write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_q <= RESET_VALUE;
    end else if (port.restoreEn) begin
      mask_q <= port.restoreData;
    end else if (port.writeEn) begin
      mask_q <= port.writeData;
    end
  end

  assign port.mask = mask_q;

endmodule : fal_mask_reg
`default_nettype wire

/* verilog/fal_trigger_top.sv */
// Severe-fault and alert trigger masks with the two active-low alarm lines.
// Assumes a protocol engine presents decoded register commands one at a time
// and that status words and tuning state arrive synchronous to clock.
//
// Contract
// - Severe line asserts when any set status bit has its mask bit set.
// - Severe mask bits 11:8 warn latches, bit 5 restart, 3:0 fatal latches.
// - Frequency, thermal and power bits raise no severe fault while unlocked.
// - Severe line releases on mask rewrite or when latched fault is cleared.
// - Masks reset to a maker value; restored saved configuration replaces it.
// - Failed mask access answers execution error, data 0x0000 and an error code.
// - Alert line asserts when any set live flag has its mask bit set.
// - Alert mask uses live flags: warn at 11:8, fatal at 3:0.
// - Alert mask defaults to 0x0404, making the line a lock indicator.
// - With alarms-during-tuning set, alert drops while tuning or output disabled.
// - Rewriting the alert mask re-evaluates the alert line one cycle after the mask changes.
`timescale 1ns/10ps
`default_nettype none
module fal_trigger_top #(
  parameter logic [15:0] SEVERE_RESET = fal_pkg::SEVERE_MASK_RESET,
  parameter logic [15:0] ALERT_RESET  = fal_pkg::ALERT_MASK_RESET
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register command from the protocol engine
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdAddr,
  input  wire logic [15:0] cmdData,
  // Execution conditions reported by the rest of the module
  input  wire logic        cmdInProgress,
  input  wire logic        cmdIgnored,
  input  wire logic        writeLocked,
  input  wire logic        execFailure,
  input  wire logic        vendorError,
  // Response to the protocol engine
  output logic             rspValid,
  output logic [1:0]       rspStatus,
  output logic [3:0]       rspError,
  output logic [15:0]      rspData,
  // Status words
  input  wire logic [15:0] latchedSevereStatus,
  input  wire logic [15:0] latchedWarningStatus,
  input  wire logic [15:0] liveStatus,
  // Laser state and configuration
  input  wire logic        laserLocked,
  input  wire logic        tuning,
  input  wire logic        outputDisabled,
  input  wire logic        alarmsDuringTuningOption,
  // Non-volatile configuration restore
  input  wire logic        nvRestore,
  input  wire logic [15:0] nvSevereMask,
  input  wire logic [15:0] nvAlertMask,
  // Alarm lines and mask readback
  output logic             severeFaultLine_n,
  output logic             alertLine_n,
  output logic [15:0]      severeFaultTriggerMask,
  output logic [15:0]      alertTriggerMask
);

  fal_mask_if severeIf ();
  fal_mask_if alertIf ();

  logic        hitSevere;
  logic        hitAlert;
  logic        accessErr;
  logic [3:0]  errCode;
  logic [15:0] severeSel;
  logic [15:0] alertSel;
  logic        rspValid_q;
  logic [1:0]  rspStatus_q;
  logic [3:0]  rspError_q;
  logic [15:0] rspData_q;
  logic        severe_q;
  logic        alert_q;
  logic [15:0] severeMask_q;
  logic [15:0] alertMask_q;

  // Any masked bit set drives the line
  function automatic logic masked_any(input logic [15:0] stat, input logic [15:0] msk);
    masked_any = |(stat & msk);
  endfunction : masked_any

  assign hitSevere = cmdValid && (cmdAddr == fal_pkg::SEVERE_MASK_ADDR);
  assign hitAlert  = cmdValid && (cmdAddr == fal_pkg::ALERT_MASK_ADDR);

  // First failing condition decides the error code
  // Reads never meet the write lock, so a locked mask stays readable
  always_comb begin
    errCode = fal_pkg::ERR_OK;
    if (cmdInProgress) begin
      errCode = fal_pkg::ERR_BUSY;
    end else if (cmdIgnored) begin
      errCode = fal_pkg::ERR_IGNORED;
    end else if (cmdWrite && writeLocked) begin
      errCode = fal_pkg::ERR_READ_ONLY;
    end else if (execFailure) begin
      errCode = fal_pkg::ERR_EXEC_FAIL;
    end else if (vendorError) begin
      errCode = fal_pkg::ERR_VENDOR;
    end
  end

  assign accessErr = (errCode != fal_pkg::ERR_OK);

  // Successful writes land in one cycle unless a same-cycle restore wins; none is ever held pending
  assign severeIf.writeEn     = hitSevere && cmdWrite && !accessErr;
  assign severeIf.writeData   = cmdData;
  assign severeIf.restoreEn   = nvRestore;
  assign severeIf.restoreData = nvSevereMask;
  assign alertIf.writeEn      = hitAlert && cmdWrite && !accessErr;
  assign alertIf.writeData    = cmdData;
  assign alertIf.restoreEn    = nvRestore;
  assign alertIf.restoreData  = nvAlertMask;

  // Restore and host write meet inside the register, where restore wins
  fal_mask_reg #(
    .RESET_VALUE (SEVERE_RESET)
  ) severeMaskReg (
    .clock (clock),
    .rst_n (rst_n),
    .port  (severeIf)
  );

  fal_mask_reg #(
    .RESET_VALUE (ALERT_RESET)
  ) alertMaskReg (
    .clock (clock),
    .rst_n (rst_n),
    .port  (alertIf)
  );

  // Both status words share one layout, so one mask covers both
  // Frequency, thermal and power bits are gated off while out of lock
  always_comb begin
    severeSel = latchedSevereStatus | latchedWarningStatus;
    if (!laserLocked) begin
      severeSel = severeSel & ~fal_pkg::LOCK_QUALIFIED_BITS;
    end
  end

  assign alertSel = liveStatus;

  // Recomputed every cycle, so clearing a latch or rewriting a mask releases
  // the line one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      severe_q <= 1'b0;
    end else begin
      severe_q <= masked_any(severeSel, severeIf.mask);
    end
  end

  // Lock-indicator use: the option forces the alert off during tuning
  // No lock gating here; out of lock only the option can silence the line
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alert_q <= 1'b0;
    end else if (alarmsDuringTuningOption && (tuning || outputDisabled)) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= masked_any(alertSel, alertIf.mask);
    end
  end

  // Mask readback ports are registered copies, one cycle behind the masks,
  // so every top-level output comes straight from a flip-flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      severeMask_q <= SEVERE_RESET;
      alertMask_q  <= ALERT_RESET;
    end else begin
      severeMask_q <= severeIf.mask;
      alertMask_q  <= alertIf.mask;
    end
  end

  // Command answer; addresses outside this block get no answer from here
  // A write beaten by a same-cycle restore still reports success and echoes
  // its data; the restored value shows on the next read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rspValid_q  <= 1'b0;
      rspStatus_q <= fal_pkg::RSP_OK;
      rspError_q  <= fal_pkg::ERR_OK;
      rspData_q   <= fal_pkg::ERROR_DATA;
    end else begin
      rspValid_q <= hitSevere || hitAlert;
      if (hitSevere || hitAlert) begin
        if (accessErr) begin
          rspStatus_q <= fal_pkg::RSP_EXEC_ERR;
          rspError_q  <= errCode;
          rspData_q   <= fal_pkg::ERROR_DATA;
        end else begin
          rspStatus_q <= fal_pkg::RSP_OK;
          rspError_q  <= fal_pkg::ERR_OK;
          if (cmdWrite) begin
            rspData_q <= cmdData;
          end else if (hitSevere) begin
            rspData_q <= severeIf.mask;
          end else begin
            rspData_q <= alertIf.mask;
          end
        end
      end
    end
  end

  assign rspValid               = rspValid_q;
  assign rspStatus              = rspStatus_q;
  assign rspError               = rspError_q;
  assign rspData                = rspData_q;
  assign severeFaultLine_n      = ~severe_q;
  assign alertLine_n            = ~alert_q;
  assign severeFaultTriggerMask = severeMask_q;
  assign alertTriggerMask       = alertMask_q;

endmodule : fal_trigger_top
`default_nettype wire

/* tb/fal_host_model.sv */
// Host model: turns one-cycle bench requests into register commands.
// Assumes go is a single-cycle pulse on clock.
`timescale 1ns/10ps
`default_nettype none
module fal_host_model (
  // Clock and request
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  ad,
  input  wire logic [15:0] wd,
  // Command port
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdAddr,
  output logic [15:0]      cmdData
);
  // Idle fields toggle so a stale value cannot pass for a command
  always_ff @(posedge clock) begin
    cmdValid <= go;
    cmdWrite <= go ? wr : ~cmdWrite;
    cmdAddr  <= go ? ad : ~cmdAddr;
    cmdData  <= go ? wd : ~cmdData;
  end
endmodule : fal_host_model
`default_nettype wire

/* tb/fal_trigger_monitor.sv */
// Checker on the trigger-mask top ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fal_trigger_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Command and answer
  input wire logic        cmdValid,
  input wire logic        cmdWrite,
  input wire logic [7:0]  cmdAddr,
  input wire logic [15:0] cmdData,
  input wire logic        cmdInProgress,
  input wire logic        nvRestore,
  input wire logic        rspValid,
  input wire logic [1:0]  rspStatus,
  input wire logic [3:0]  rspError,
  input wire logic [15:0] rspData,
  // Status, state and lines
  input wire logic [15:0] latchedSevereStatus,
  input wire logic [15:0] latchedWarningStatus,
  input wire logic [15:0] liveStatus,
  input wire logic        laserLocked,
  input wire logic        tuning,
  input wire logic        outputDisabled,
  input wire logic        alarmsDuringTuningOption,
  input wire logic        severeFaultLine_n,
  input wire logic        alertLine_n,
  input wire logic [15:0] severeFaultTriggerMask,
  input wire logic [15:0] alertTriggerMask
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic isMask;
  assign isMask = cmdValid && (cmdAddr == 8'h29 || cmdAddr == 8'h2a);
  sequence altWrite;
    isMask && cmdWrite && cmdAddr == 8'h2a && !nvRestore ##1 rspStatus == 2'h0;
  endsequence
  chk_answer_next: assert property (isMask |=> rspValid)
    else $error("no answer");
  chk_other_quiet: assert property (cmdValid && !isMask |=> !rspValid)
    else $error("answer to other address");
  chk_error_zero: assert property (rspValid && rspStatus == 2'h1 |-> rspData == 16'h0000)
    else $error("error data not zero");
  chk_busy_first: assert property (isMask && cmdInProgress |=> rspError == 4'h3)
    else $error("busy code wrong");
  chk_write_lands: assert property (altWrite |-> rspData == $past(cmdData)
    ##1 alertTriggerMask == $past(cmdData, 2)) else $error("write lost");
  chk_severe_line: assert property ($past(rst_n) |-> severeFaultLine_n ==
    !(|($past(latchedSevereStatus | latchedWarningStatus) & severeFaultTriggerMask
    & ($past(laserLocked) ? 16'hffff : 16'hf8f8)))) else $error("severe line wrong");
  chk_alert_line: assert property ($past(rst_n) |-> alertLine_n ==
    !(|($past(liveStatus) & alertTriggerMask) && !$past(alarmsDuringTuningOption
    && (tuning || outputDisabled)))) else $error("alert line wrong");
  chk_reset_masks: assert property (disable iff (1'b0) !rst_n |=>
    severeFaultTriggerMask == 16'h000f && alertTriggerMask == 16'h0404)
    else $error("reset masks wrong");
endmodule : fal_trigger_monitor
bind fal_trigger_top fal_trigger_monitor fal_trigger_monitor_inst (.*);
`default_nettype wire

/* tb/test_fal_trigger_top.sv */
// Bench for the trigger-mask block: commands through the host model.
// Assumes answers and line changes follow the hand-over timing.
`timescale 1ns/10ps
`default_nettype none
module test_fal_trigger_top;
  logic        clock, rst_n, go, wr, cmdValid, cmdWrite, rspValid, nvRestore;
  logic        cmdInProgress, cmdIgnored, writeLocked, execFailure, vendorError;
  logic        laserLocked, tuning, outputDisabled, alarmsDuringTuningOption;
  logic        severeFaultLine_n, alertLine_n;
  logic [1:0]  rspStatus;
  logic [3:0]  rspError;
  logic [7:0]  ad, cmdAddr;
  logic [15:0] wd, cmdData, rspData, latchedSevereStatus, latchedWarningStatus, liveStatus;
  logic [15:0] nvSevereMask, nvAlertMask, severeFaultTriggerMask, alertTriggerMask;
  int          mismatches, n_checks;
  int          pos [9] = '{11, 10, 9, 8, 5, 3, 2, 1, 0};
  logic [3:0]  code [5] = '{4'h3, 4'h4, 4'h1, 4'h5, 4'hf};
  fal_host_model fal_host_model_inst (.*);
  fal_trigger_top fal_trigger_top_inst (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic results;
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] exp, input logic [3:0] err);
    int k;
    k = 0;
    @(posedge clock);
    {go, wr, ad, wd} <= {1'b1, w, a, d};
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (rspValid !== 1'b1 && k < 4);
    cmp({15'h0, rspValid}, {15'h0, a == 8'h29 || a == 8'h2a});
    if (rspValid === 1'b1) begin
      cmp(rspData, exp);
      cmp({11'h0, rspStatus == 2'h1, rspError}, {11'h0, err != 4'h0, err});
    end else if (a == 8'h29 || a == 8'h2a) results();
  endtask : acc
  // Status words and lock change together, then both lines are sampled
  task automatic stl(input logic [15:0] sv, input logic [15:0] wn, input logic [15:0] lv,
                     input logic lk, input logic s, input logic a);
    @(posedge clock);
    {latchedSevereStatus, latchedWarningStatus, liveStatus, laserLocked} <= {sv, wn, lv, lk};
    repeat (2) @(posedge clock);
    #1;
    cmp({14'h0, severeFaultLine_n, alertLine_n}, {14'h0, s, a});
  endtask : stl
  initial begin
    {rst_n, go, wr, ad, wd, nvRestore, nvSevereMask, nvAlertMask} = '0;
    {cmdInProgress, cmdIgnored, writeLocked, execFailure, vendorError} = '0;
    {latchedSevereStatus, latchedWarningStatus, liveStatus} = '0;
    {laserLocked, tuning, outputDisabled, alarmsDuringTuningOption} = 4'h8;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    acc(1'b0, 8'h29, 16'h0, 16'h000f, 4'h0);
    acc(1'b0, 8'h2a, 16'h0, 16'h0404, 4'h0);
    acc(1'b0, 8'h30, 16'h0, 16'h0, 4'h0);
    stl(16'h0, 16'h0, 16'h0400, 1'b1, 1'b1, 1'b0);
    stl(16'h0001, 16'h0, 16'h0, 1'b1, 1'b0, 1'b1);
    stl(16'h0004, 16'h0, 16'h0, 1'b0, 1'b1, 1'b1);
    stl(16'h0008, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1);
    for (int j = 0; j < 9; j++) begin
      acc(1'b1, 8'h29, 16'h1 << pos[j], 16'h1 << pos[j], 4'h0);
      stl(16'h0, 16'h1 << pos[j], 16'h0, 1'b1, 1'b0, 1'b1);
      stl(~(16'h1 << pos[j]), 16'h0, 16'h0, 1'b1, 1'b1, 1'b1);
    end
    stl(16'h0001, 16'h0, 16'h0, 1'b1, 1'b0, 1'b1);
    acc(1'b1, 8'h29, 16'h0100, 16'h0100, 4'h0);
    stl(16'h0001, 16'h0, 16'h0, 1'b1, 1'b1, 1'b1);
    acc(1'b1, 8'h2a, 16'h0002, 16'h0002, 4'h0);
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    {alarmsDuringTuningOption, tuning} <= 2'h3;
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b1);
    @(posedge clock);
    {alarmsDuringTuningOption, tuning, outputDisabled} <= 3'h5;
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b1);
    @(posedge clock);
    {alarmsDuringTuningOption, tuning, outputDisabled} <= 3'h1;
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    {alarmsDuringTuningOption, tuning, outputDisabled} <= 3'h4;
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b0);
    @(posedge clock);
    {alarmsDuringTuningOption, tuning, outputDisabled} <= 3'h0;
    acc(1'b1, 8'h2a, 16'h0800, 16'h0800, 4'h0);
    stl(16'h0, 16'h0, 16'h0002, 1'b1, 1'b1, 1'b1);
    for (int j = 0; j < 5; j++) begin
      @(posedge clock);
      {cmdInProgress, cmdIgnored, writeLocked, execFailure, vendorError} <= 5'h10 >> j;
      acc(1'b1, 8'h2a, 16'h5a5a, 16'h0, code[j]);
      acc(1'b0, 8'h2a, 16'h0, (j == 2) ? 16'h0800 : 16'h0, (j == 2) ? 4'h0 : code[j]);
    end
    @(posedge clock);
    {cmdInProgress, cmdIgnored, writeLocked, execFailure, vendorError} <= 5'h00;
    {nvRestore, nvSevereMask, nvAlertMask} <= {1'b1, 16'h0123, 16'h0c05};
    @(posedge clock);
    nvRestore <= 1'b0;
    acc(1'b0, 8'h29, 16'h0, 16'h0123, 4'h0);
    acc(1'b0, 8'h2a, 16'h0, 16'h0c05, 4'h0);
    // Restore lands on the same edge as a host write and must win
    fork
      acc(1'b1, 8'h2a, 16'h0f0f, 16'h0f0f, 4'h0);
      begin
        repeat (2) @(posedge clock);
        {nvRestore, nvAlertMask} <= {1'b1, 16'h0003};
        @(posedge clock);
        nvRestore <= 1'b0;
      end
    join
    acc(1'b0, 8'h2a, 16'h0, 16'h0003, 4'h0);
    acc(1'b0, 8'h29, 16'h0, 16'h0123, 4'h0);
    results();
  end
endmodule : test_fal_trigger_top
`default_nettype wire
